// ==== shared/wcc_map.svh ====
/*
  register offsets, field positions and reset values of the wide counter control block.
  assumes inclusion by name from shared/; definitions only.
*/
`ifndef WCC_MAP_SVH
`define WCC_MAP_SVH
`define WCC_OFS_CTRL 12'h000
`define WCC_OFS_DUAL 12'h004
`define WCC_OFS_MODE 12'h008
`define WCC_OFS_STAT 12'h00C
`define WCC_OFS_MASK 12'h010
`define WCC_OFS_CNT 12'h014
`define WCC_OFS_RELOAD 12'h018
`define WCC_OFS_CAPT 12'h01C
`define WCC_BIT_RUN 7
`define WCC_BIT_TERM 6
`define WCC_BIT_TOUT 5
`define WCC_BIT_PRE_HI 4
`define WCC_BIT_PRE_LO 3
`define WCC_BIT_CAPIE 2
`define WCC_BIT_TOIE 1
`define WCC_BIT_PINSEL 0
`define WCC_BIT_DUAL_RUN 7
`define WCC_BIT_MODE_DEMOD 7
`define WCC_BIT_EV_TOUT 0
`define WCC_BIT_EV_CAPT 1
`define WCC_RST_CTRL 8'h00
`define WCC_RST_DUAL 8'h00
`define WCC_RST_MODE 8'h00
`define WCC_RST_RELOAD 16'hFFFF
`define WCC_PRE_DIV1 3'h0
`define WCC_PRE_DIV2 3'h1
`define WCC_PRE_DIV4 3'h3
`define WCC_PRE_MAX 3'h7
`endif

// ==== shared/wcc_pkg.sv ====
/*
  types of the wide counter control block.
  assumes wcc_map.svh defines the constants.
*/
package wcc_pkg;
  typedef struct packed {
    logic run;
    logic term_halt;
    logic tout;
    logic [1:0] prescale;
    logic cap_ie;
    logic tout_ie;
    logic pin_sel;
  } wcc_ctrl_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wcc_apb_req_s;
  typedef enum logic [1:0] {
    WCC_ST_IDLE = 2'b00,
    WCC_ST_COUNT = 2'b01,
    WCC_ST_HALT = 2'b10
  } wcc_state_e;
endpackage : wcc_pkg

// ==== hw/wcc_prescaler.sv ====
/*
  divider producing a count tick every 1, 2, 4 or 8 clocks.
  assumes a single pclk domain.
*/
`timescale 1ns/1ps
`include "wcc_map.svh"
module wcc_prescaler (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic run, // divider enable
  input wire logic [1:0] sel, // divide select
  output logic tick // one-cycle count tick
);
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic [2:0] lim;
  always_comb begin
    case (sel)
      2'b00: lim = `WCC_PRE_DIV1;
      2'b01: lim = `WCC_PRE_DIV2;
      2'b10: lim = `WCC_PRE_DIV4;
      default: lim = `WCC_PRE_MAX;
    endcase
    div_d = 3'h0;
    if (run && div_q < lim) begin
      div_d = div_q + 3'h1;
    end
    tick = run && (div_q >= lim);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_d;
    end
  end
endmodule : wcc_prescaler

// ==== hw/wcc_top.sv ====
/*
  wide counter control register, 16-bit down counter, capture and interrupts over APB.
  assumes an APB master on pclk; capture edge pin asynchronous; stop recovery is a pulse.
*/
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "wcc_map.svh"
// What this block does
// - counter runs while own enable or duplicate enable is set
// - transmit mode: terminal bit 0 reloads, 1 halts at terminal count
// - demodulation: bit 0 captures on all edges, 1 on first edge only
// - terminal count sets the sticky time-out flag
// - writing one clears the time-out flag, zero leaves it
// - clock select divides counter clock by 1, 2, 4 or 8
// - clock select survives stop-mode recovery
// - capture interrupt enable gates capture interrupt requests
// - capture interrupt enable survives stop-mode recovery
// - time-out interrupt enable gates time-out interrupt requests
// - bit 0 routes counter output or port data to the pin
// - mode register bit 7 chooses transmit (0) or demodulation
module wcc_top (
  input wire logic pclk, // system clock 40 MHz
  input wire logic presetn, // async reset, low
  input wire logic stop_recover, // stop-mode recovery pulse
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic edge_in, // demodulation input pin
  input wire logic port_data, // ordinary port output value
  output logic port3_pin5, // pin output
  output logic irq // level interrupt
);
  import wcc_pkg::*;
  wcc_apb_req_s req;
  wcc_ctrl_s ctrl_q, ctrl_d;
  logic [7:0] dual_q, dual_d, mode_q, mode_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic [15:0] cnt_q, cnt_d, reload_q, reload_d, capt_q, capt_d;
  logic out_q, out_d, first_q, first_d;
  logic [2:0] sync_q;
  logic [31:0] rdata_q, rdata_d;
  wcc_state_e st_q, st_d;
  logic wr, rd, tick, run, demod, tc, edge_ev, capt_ev, tout_ev;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign wr = req.psel && req.penable && req.pwrite;
  assign rd = req.psel && !req.penable && !req.pwrite;
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = req.psel && req.penable && !(hit(req.paddr, `WCC_OFS_CTRL)
    || hit(req.paddr, `WCC_OFS_DUAL) || hit(req.paddr, `WCC_OFS_MODE)
    || hit(req.paddr, `WCC_OFS_STAT) || hit(req.paddr, `WCC_OFS_MASK)
    || hit(req.paddr, `WCC_OFS_CNT) || hit(req.paddr, `WCC_OFS_RELOAD)
    || hit(req.paddr, `WCC_OFS_CAPT));

  assign run = ctrl_q.run || dual_q[`WCC_BIT_DUAL_RUN];
  assign demod = mode_q[`WCC_BIT_MODE_DEMOD];
  assign edge_ev = sync_q[2] != sync_q[1];

  wcc_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .sel(ctrl_q.prescale),
    .tick(tick)
  );

  // counter state machine
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    capt_d = capt_q;
    out_d = out_q;
    first_d = first_q;
    tc = 1'b0;
    capt_ev = 1'b0;
    case (st_q)
      WCC_ST_IDLE: begin
        if (run) begin
          st_d = WCC_ST_COUNT;
          cnt_d = reload_q;
          first_d = 1'b1;
        end
      end
      WCC_ST_COUNT: begin
        if (!run) begin
          st_d = WCC_ST_IDLE;
        end else if (demod && edge_ev && (first_q || !ctrl_q.term_halt)) begin
          capt_d = reload_q - cnt_q;
          cnt_d = reload_q;
          capt_ev = 1'b1;
          first_d = 1'b0;
        end else if (tick) begin
          if (cnt_q == 16'h0000) begin
            tc = 1'b1;
            out_d = !out_q;
            if (!demod && ctrl_q.term_halt) begin
              st_d = WCC_ST_HALT;
            end else begin
              cnt_d = reload_q;
            end
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      end
      WCC_ST_HALT: begin
        if (!run) begin
          st_d = WCC_ST_IDLE;
        end
      end
      default: st_d = WCC_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= WCC_ST_IDLE;
      cnt_q <= 16'h0000;
      capt_q <= 16'h0000;
      out_q <= 1'b0;
      first_q <= 1'b0;
      sync_q <= 3'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      capt_q <= capt_d;
      out_q <= out_d;
      first_q <= first_d;
      sync_q <= {sync_q[1:0], edge_in};
    end
  end

  assign tout_ev = tc;

  // register file next values
  always_comb begin
    ctrl_d = ctrl_q;
    dual_d = dual_q;
    mode_d = mode_q;
    mask_d = mask_q;
    reload_d = reload_q;
    stat_d = stat_q;
    rdata_d = rdata_q;
    if (stop_recover) begin
      ctrl_d = '0;
      ctrl_d.prescale = ctrl_q.prescale;
      ctrl_d.cap_ie = ctrl_q.cap_ie;
      ctrl_d.tout = ctrl_q.tout;
    end
    if (wr && hit(req.paddr, `WCC_OFS_CTRL)) begin
      ctrl_d = req.pwdata[7:0];
      ctrl_d.tout = ctrl_q.tout && !req.pwdata[`WCC_BIT_TOUT];
    end
    if (wr && hit(req.paddr, `WCC_OFS_DUAL)) begin
      dual_d = req.pwdata[7:0];
    end
    if (wr && hit(req.paddr, `WCC_OFS_MODE)) begin
      mode_d = req.pwdata[7:0];
    end
    if (wr && hit(req.paddr, `WCC_OFS_MASK)) begin
      mask_d = req.pwdata[1:0];
    end
    if (wr && hit(req.paddr, `WCC_OFS_RELOAD)) begin
      reload_d = req.pwdata[15:0];
    end
    if (wr && hit(req.paddr, `WCC_OFS_STAT)) begin
      stat_d = stat_q & ~req.pwdata[1:0];
    end
    if (tout_ev) begin
      ctrl_d.tout = 1'b1;
      stat_d[`WCC_BIT_EV_TOUT] = 1'b1;
    end
    if (capt_ev) begin
      stat_d[`WCC_BIT_EV_CAPT] = 1'b1;
    end
    if (rd) begin
      case (req.paddr)
        `WCC_OFS_CTRL: rdata_d = {24'h000000, ctrl_q};
        `WCC_OFS_DUAL: rdata_d = {24'h000000, dual_q};
        `WCC_OFS_MODE: rdata_d = {24'h000000, mode_q};
        `WCC_OFS_STAT: rdata_d = {30'h00000000, stat_q};
        `WCC_OFS_MASK: rdata_d = {30'h00000000, mask_q};
        `WCC_OFS_CNT: rdata_d = {16'h0000, cnt_q};
        `WCC_OFS_RELOAD: rdata_d = {16'h0000, reload_q};
        `WCC_OFS_CAPT: rdata_d = {16'h0000, capt_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `WCC_RST_CTRL;
      dual_q <= `WCC_RST_DUAL;
      mode_q <= `WCC_RST_MODE;
      mask_q <= 2'h0;
      stat_q <= 2'h0;
      reload_q <= `WCC_RST_RELOAD;
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      dual_q <= dual_d;
      mode_q <= mode_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      reload_q <= reload_d;
      rdata_q <= rdata_d;
    end
  end

  // interrupt gates on both the enable bits and the mask register
  assign irq = |(stat_q & mask_q & {ctrl_q.cap_ie, ctrl_q.tout_ie});
  assign port3_pin5 = ctrl_q.pin_sel ? out_q : port_data;

  a_run_either: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == WCC_ST_IDLE && (ctrl_q.run || dual_q[7])) |=> st_q == WCC_ST_COUNT)
    else $error("counter did not start on an enable");
  a_halt_term: assert property (@(posedge pclk) disable iff (!presetn)
    (tc && !demod && ctrl_q.term_halt) |=> st_q == WCC_ST_HALT)
    else $error("counter did not halt at terminal count");
  a_reload_term: assert property (@(posedge pclk) disable iff (!presetn)
    (tc && !ctrl_q.term_halt && st_d == WCC_ST_COUNT) |=> cnt_q == $past(reload_q))
    else $error("counter did not reload at terminal count");
  a_first_only: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == WCC_ST_COUNT && demod && ctrl_q.term_halt && !first_q) |-> !capt_ev)
    else $error("capture after first edge in single mode");
  a_tout_set: assert property (@(posedge pclk) disable iff (!presetn)
    tc |=> ctrl_q.tout && stat_q[0])
    else $error("time-out flag not set");
  a_tout_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == 12'h000 && pwdata[5] && !tc) |=> !ctrl_q.tout)
    else $error("time-out flag not cleared by one");
  a_tout_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.tout && !(wr && paddr == 12'h000 && pwdata[5])) |=> ctrl_q.tout)
    else $error("time-out flag lost");
  a_pre_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (stop_recover && !wr) |=> ctrl_q.prescale == $past(ctrl_q.prescale)
      && ctrl_q.cap_ie == $past(ctrl_q.cap_ie))
    else $error("stop recovery changed kept fields");
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.tout_ie && !ctrl_q.cap_ie) |-> !irq)
    else $error("interrupt with both enables clear");
  a_pin_route: assert property (@(posedge pclk) disable iff (!presetn)
    port3_pin5 == (ctrl_q.pin_sel ? out_q : port_data))
    else $error("pin routing wrong");
endmodule : wcc_top

// ==== verif/test_wide_counter_control.sv ====
/*
  self-checking bench for the wide counter control block over APB.
  assumes wcc_top, wcc_pkg and wcc_map.svh from hw/ and shared/.
*/
`timescale 1ns/1ps
`include "wcc_map.svh"
module test_wide_counter_control;
  import wcc_pkg::*;
  logic pclk, presetn, stop_recover, psel, penable, pwrite, edge_in, port_data;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, c0, seed;
  logic pready, pslverr, port3_pin5, irq;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int mismatches, check_count;
  wcc_top dut_u (.pclk(pclk), .presetn(presetn), .stop_recover(stop_recover), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .edge_in(edge_in), .port_data(port_data),
    .port3_pin5(port3_pin5), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // one apb transfer; reads note their expectation for the monitor
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rv = prdata;
    check("pready", n, 32'h1);
    check("pslverr", {31'h0, pslverr}, {31'h0, a > `WCC_OFS_CAPT});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    xfer(1'b0, a, 32'h0, e, m);
  endtask : rd
  task automatic tog();
    edge_in <= ~edge_in;
    repeat (10) @(posedge pclk);
  endtask : tog
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check("prdata", prdata & msk_q.pop_front(), exp_q.pop_front());
  end
  initial begin
    #1000000;
    mismatches++;
    stop_test();
  end
  initial begin
    {presetn, stop_recover, psel, penable, pwrite, edge_in, port_data} = '0;
    paddr = '0;
    pwdata = '0;
    seed = 32'hB4CF4863;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rd(12'(i * 4), 32'h0);
    rd(`WCC_OFS_RELOAD, 32'hFFFF);
    rd(12'h020, 32'h0);
    wr(`WCC_OFS_CTRL, 32'h20);
    for (int i = 0; i < 4; i++) begin
      c0 = xs();
      port_data <= c0[8];
      wr(`WCC_OFS_CTRL, c0 & 32'h5E);
      rd(`WCC_OFS_CTRL, c0 & 32'h5E);
      check("pin", {31'h0, port3_pin5}, {31'h0, port_data});
    end
    // run through duplicate enable only, interrupt first disabled
    wr(`WCC_OFS_RELOAD, 32'h5);
    wr(`WCC_OFS_MASK, 32'h3);
    wr(`WCC_OFS_CTRL, 32'h0);
    wr(`WCC_OFS_DUAL, 32'h80);
    repeat (20) @(posedge pclk);
    rd(`WCC_OFS_CTRL, 32'h20);
    rd(`WCC_OFS_STAT, 32'h1, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    wr(`WCC_OFS_CTRL, 32'h02);
    check("irq", {31'h0, irq}, 32'h1);
    wr(`WCC_OFS_DUAL, 32'h0);
    rd(`WCC_OFS_CTRL, 32'h22);
    wr(`WCC_OFS_CTRL, 32'h22);
    wr(`WCC_OFS_STAT, 32'h1);
    repeat (20) @(posedge pclk);
    rd(`WCC_OFS_CTRL, 32'h02);
    check("irq", {31'h0, irq}, 32'h0);
    // halt versus reload at terminal count, transmit mode
    wr(`WCC_OFS_RELOAD, 32'h3);
    wr(`WCC_OFS_CTRL, 32'h01);
    c0 = {31'h0, port3_pin5};
    wr(`WCC_OFS_CTRL, 32'hC1);
    repeat (20) @(posedge pclk);
    rd(`WCC_OFS_CNT, 32'h0);
    check("pin", {31'h0, port3_pin5}, {31'h0, ~c0[0]});
    wr(`WCC_OFS_CTRL, 32'hE0);
    repeat (20) @(posedge pclk);
    rd(`WCC_OFS_CTRL, 32'hC0);
    rd(`WCC_OFS_CNT, 32'h0);
    wr(`WCC_OFS_CTRL, 32'h20);
    wr(`WCC_OFS_CTRL, 32'hA0);
    repeat (20) @(posedge pclk);
    wr(`WCC_OFS_CTRL, 32'hA0);
    repeat (20) @(posedge pclk);
    rd(`WCC_OFS_CTRL, 32'hA0);
    // tick rate per divide select over a 64-cycle window
    wr(`WCC_OFS_RELOAD, 32'hFFFF);
    for (int s = 0; s < 4; s++) begin
      wr(`WCC_OFS_CTRL, 32'hA0 | (s << 3));
      repeat (8) @(posedge pclk);
      rd(`WCC_OFS_CNT, 32'h0, 32'h0);
      c0 = rv;
      repeat (61) @(posedge pclk);
      rd(`WCC_OFS_CNT, 32'h0, 32'h0);
      c0 = (c0 - rv) & 32'hFFFF;
      check("ticks", {31'h0, c0 + 1 >= (64 >> s) && c0 <= (64 >> s) + 1}, 32'h1);
    end
    // demodulation capture, every edge then first edge only
    wr(`WCC_OFS_CTRL, 32'h20);
    wr(`WCC_OFS_MODE, 32'h80);
    wr(`WCC_OFS_MASK, 32'h2);
    wr(`WCC_OFS_STAT, 32'h3);
    wr(`WCC_OFS_CTRL, 32'h80);
    tog();
    rd(`WCC_OFS_STAT, 32'h2, 32'h2);
    check("irq", {31'h0, irq}, 32'h0);
    wr(`WCC_OFS_CTRL, 32'h84);
    check("irq", {31'h0, irq}, 32'h1);
    wr(`WCC_OFS_STAT, 32'h2);
    tog();
    rd(`WCC_OFS_STAT, 32'h2, 32'h2);
    wr(`WCC_OFS_CTRL, 32'h20);
    wr(`WCC_OFS_STAT, 32'h3);
    wr(`WCC_OFS_CTRL, 32'hC4);
    tog();
    rd(`WCC_OFS_STAT, 32'h2, 32'h2);
    wr(`WCC_OFS_STAT, 32'h2);
    tog();
    rd(`WCC_OFS_STAT, 32'h0, 32'h2);
    check("irq", {31'h0, irq}, 32'h0);
    // stop recovery keeps only divide select, capture enable and the time-out flag
    wr(`WCC_OFS_CTRL, 32'h20);
    wr(`WCC_OFS_MODE, 32'h0);
    wr(`WCC_OFS_CTRL, 32'h5F);
    stop_recover <= 1'b1;
    @(posedge pclk);
    stop_recover <= 1'b0;
    @(posedge pclk);
    rd(`WCC_OFS_CTRL, 32'h1C);
    check("pin", {31'h0, port3_pin5}, {31'h0, port_data});
    stop_test();
  end
endmodule : test_wide_counter_control
